// >>> sim/hbf_far_station.sv
/*
  Far station model: makes both bit clocks, records every bit sent by the
  framer and replays queued bits toward it.
  Assumes the framer drives tx after falling tx_clk and samples rx on rising.
*/
`timescale 1ns/100ps
module hbf_far_station (
  input  wire logic tx_data,
  output logic      tx_clk,
  output logic      rx_clk,
  output logic      rx_data
);
  bit cap[$];
  bit rxq[$];
  initial begin
    tx_clk  = 1'b0;
    rx_clk  = 1'b0;
    rx_data = 1'b1;
  end
  // ==========================================
  // clocks: unrelated periods, many core cycles per bit
  always #800 tx_clk = ~tx_clk;
  always #850 rx_clk = ~rx_clk;
  always @(posedge tx_clk) cap.push_back(tx_data);
  // nothing queued: the line marks, so long runs of ones mean idle
  always @(negedge rx_clk) begin
    if (rxq.size() != 0) rx_data <= rxq.pop_front();
    else rx_data <= 1'b1;
  end
endmodule // hbf_far_station

// >>> sim/test_hdlc_bit_oriented_framer.sv
/*
  Self-checking bench for the framer: register tasks, frame encoder and
  decoder, fcs model, scenarios for both directions.
  Assumes the far station model drives the serial pins.
*/
`timescale 1ns/100ps
module test_hdlc_bit_oriented_framer
  import hbf_pkg::*;
;
  typedef logic [7:0] hbf_bq_t[$];
  logic       core_clk = 1'b0;
  logic       rst_n;
  logic [7:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic       cpu_wr;
  logic       cpu_rd;
  logic [7:0] cpu_rdata;
  logic       tx_clk;
  logic       tx_data;
  logic       rx_clk;
  logic       rx_data;
  logic       tx_underrun;
  int         miscompares;
  int         total_checks;
  hbf_bq_t    q;

  always #50 core_clk = ~core_clk;
  hbf_framer u_dut (.core_clk(core_clk), .rst_n(rst_n), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
    .tx_clk_pin(tx_clk), .tx_data(tx_data), .rx_clk_pin(rx_clk), .rx_data_pin(rx_data),
    .tx_underrun(tx_underrun));
  hbf_far_station u_far (.tx_data(tx_data), .tx_clk(tx_clk), .rx_clk(rx_clk),
    .rx_data(rx_data));

  // ==========================================
  // compare, register access
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge core_clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    @(posedge core_clk);
    cpu_rd <= 1'b0;
    @(posedge core_clk);
    chk(cpu_rdata & m, e);
  endtask
  task automatic wait_bits(input int n);
    repeat (n * 16) @(posedge core_clk);
  endtask
  function automatic hbf_bq_t rbytes(input int n);
    hbf_bq_t r;
    repeat (n) r.push_back(8'($urandom_range(255)));
    return r;
  endfunction
  function automatic logic [15:0] fcs(input hbf_bq_t b);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) for (int j = 0; j < 8; j++) c = (c >> 1) ^ ((c[0] ^ b[i][j]) ? CRC_POLY : 16'h0);
    return c;
  endfunction

  // ==========================================
  // line decoder: 0 closed frame, 1 abort, 2 ragged length, 3 nothing
  function automatic int decode(output hbf_bq_t r);
    logic [7:0] sh;
    bit         d[$];
    int         ones;
    int         st;
    sh   = 8'h00;
    ones = 0;
    st   = 0;
    r    = {};
    foreach (u_far.cap[i]) begin
      if (st == 0) begin
        sh = {u_far.cap[i], sh[7:1]};
        if (sh == FLAG) st = 1;
      end else if (u_far.cap[i]) begin
        ones++;
        if (ones == 7) return 1;
        if (ones < 6) d.push_back(1'b1);
      end else begin
        if (ones == 6) begin
          repeat (6) void'(d.pop_back());
          // an empty frame is flag fill, keep looking
          if (d.size() != 0) begin
            foreach (d[k]) begin
              if (k % 8 == 0) r.push_back(8'h00);
              r[k/8][k%8] = d[k];
            end
            return (d.size() % 8 == 0) ? 0 : 2;
          end
        end else if (ones != 5) d.push_back(1'b0);
        ones = 0;
      end
    end
    return 3;
  endfunction
  task automatic tx_check(input hbf_bq_t e, input bit nofcs, input int code);
    hbf_bq_t r;
    chk(decode(r), code);
    if (code == 0) begin
      chk(r.size(), e.size() + (nofcs ? 0 : 2));
      if (!nofcs) chk(fcs(r), CRC_GOOD);
      foreach (e[i]) chk(r[i], e[i]);
    end
  endtask
  // mode 0 good fcs, 1 corrupt fcs, 2 no fcs at all, 3 abort then go-ahead
  task automatic rx_frame(input hbf_bq_t b, input int mode);
    logic [15:0] c;
    int          ones;
    c    = ~fcs(b) ^ ((mode == 1) ? 16'h0001 : 16'h0000);
    ones = 0;
    if (mode < 2) b.push_back(c[7:0]);
    if (mode < 2) b.push_back(c[15:8]);
    for (int j = 0; j < 8; j++) u_far.rxq.push_back(FLAG[j]);
    foreach (b[i]) for (int j = 0; j < 8; j++) begin
      u_far.rxq.push_back(b[i][j]);
      ones = b[i][j] ? ones + 1 : 0;
      if (ones == 5) u_far.rxq.push_back(1'b0);
      if (ones == 5) ones = 0;
    end
    for (int j = 0; j < 8; j++) u_far.rxq.push_back(FLAG[j] | (mode == 3));
    if (mode == 3) for (int j = 0; j < 9; j++) u_far.rxq.push_back(j % 8 != 0);
    for (int t = 0; t < 4000 && u_far.rxq.size() != 0; t++) @(posedge core_clk);
    repeat (60) @(posedge core_clk);
  endtask
  task automatic rx_expect(input hbf_bq_t b, input bit good);
    foreach (b[i]) begin
      if (good || i == b.size() - 1)
        rchk(A_STAT, 8'hc0, (i == b.size() - 1) ? {1'b1, !good, 6'h0} : 8'h00);
      rchk(A_FIFO, 8'hff, b[i]);
    end
    rchk(A_STAT, 8'h01, 8'h01);
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #4000000;
    miscompares++;
    summarize();
  end

  // ==========================================
  // scenarios
  initial begin
    rst_n     = 1'b0;
    cpu_addr  = 8'h00;
    cpu_wdata = 8'h00;
    cpu_wr    = 1'b0;
    cpu_rd    = 1'b0;
    void'($urandom(32'h0bcf));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rchk(A_CTRL1, 8'hff, 8'h00);
    rchk(A_CTRL2, 8'hff, 8'h00);
    rchk(8'h00, 8'hff, 8'h00);
    chk(tx_underrun, 1'b0);
    // queue a packet while disabled, then enable from ones idle
    q    = rbytes(4);
    q[1] = 8'hff;
    u_far.cap.delete();
    wr(A_CTRL1, 8'h40);
    for (int i = 0; i < 3; i++) wr(A_FIFO, q[i]);
    wr(A_CTRL1, 8'h50);
    wr(A_FIFO, q[3]);
    rchk(A_CTRL1, 8'hff, 8'h40);
    wr(A_CTRL1, 8'h60);
    wait_bits(120);
    tx_check(q, 1'b0, 0);
    // flag fill, end tagged by the byte count, fcs inhibited
    q = rbytes(3);
    u_far.cap.delete();
    wr(A_CTRL1, 8'h64);
    wr(A_CTRL2, 8'h03);
    wr(A_COUNT, 8'h03);
    foreach (q[i]) wr(A_FIFO, q[i]);
    rchk(A_COUNT, 8'hff, 8'h03);
    wait_bits(100);
    tx_check(q, 1'b1, 0);
    // abort tag replaces the byte
    wr(A_CTRL2, 8'h00);
    wr(A_COUNT, 8'h00);
    wr(A_CTRL1, 8'h60);
    // let the flag fill run out so the opening flag is captured whole
    wait_bits(20);
    q = rbytes(2);
    u_far.cap.delete();
    wr(A_FIFO, q[0]);
    wr(A_CTRL1, 8'h68);
    wr(A_FIFO, q[1]);
    wait_bits(60);
    tx_check(q, 1'b0, 1);
    chk(tx_underrun, 1'b0);
    // lone untagged byte underruns
    u_far.cap.delete();
    wr(A_FIFO, q[0]);
    wait_bits(60);
    tx_check(q, 1'b0, 1);
    chk(tx_underrun, 1'b1);
    rchk(A_STAT, 8'h02, 8'h02);
    wr(A_STAT, 8'h02);
    rchk(A_STAT, 8'h02, 8'h00);
    // receive good, bad and short frames
    q    = rbytes(7);
    q[2] = 8'hff;
    rx_frame(q, 0);
    rx_expect(q, 1'b1);
    rx_frame(q, 1);
    rx_expect(q, 1'b0);
    rx_frame(rbytes(2), 2);
    rchk(A_STAT, 8'h01, 8'h01);
    wait_bits(20);
    rchk(A_STAT, 8'h08, 8'h08);
    // abort after five bytes ending in four ones; stores trail the line by
    // 23 bits, so only the first two bytes land, the second tagged bad
    q    = rbytes(5);
    q[4] = 8'hf0;
    rx_frame(q, 3);
    rx_expect(q[0:1], 1'b0);
    rchk(A_STAT, 8'h04, 8'h04);
    wr(A_STAT, 8'h04);
    rchk(A_STAT, 8'h04, 8'h00);
    // soft reset wipes control
    wr(A_CTRL1, 8'h64);
    wr(A_SRST, 8'h01);
    rchk(A_CTRL1, 8'hff, 8'h00);
    summarize();
  end
endmodule // test_hdlc_bit_oriented_framer

// >>> verilog/hbf_framer.sv
/*
  Bit-oriented packet framer: processor register port, tagged transmit and
  receive FIFOs, serial transmitter and receiver.
  Assumes serial bit clocks far slower than core_clk (several core cycles
  per bit) and processor strobes that last one core cycle.
*/
// Notes on behaviour
// - transmitter inserts a zero after five ones, FCS included
// - receiver drops the zero after five ones inside a frame
// - bad residue tags the final stored byte as bad packet
// - frames under 25 bits leave nothing in the receive FIFO
// - frames of 25 to 31 bits are stored with last byte tagged bad
// - seven ones in a frame of 26 bits or more abort it as bad
// - trailing ones of the last byte count toward those seven
// - fifteen or more ones mean the link is idle
// - seven ones then a zero is a go-ahead, kept apart from aborts
// - reset pin or soft reset clears all control, both ends disabled
// - each received byte carries two status bits
// - transmit entries hold data plus end and abort tags from control
// - idle sends ones; mark-idle bit selects continuous flags
// - end and abort tag bits clear after each FIFO write
// - byte count drops per write, tags end at one, reloads in cycle mode
// - data from ones idle gets an opening flag, else follows the flag
// - end byte is followed by FCS and one flag shared between packets
// - abort tagged byte is replaced by zero and seven ones, then fill
// - empty FIFO after an untagged byte is underrun and sends abort
// - enable acts at once; disable waits for the packet to finish
// - FCS inhibit sends flags and stuffed data without FCS
// - status 11 last bad, 10 last good, 00 plain byte; 01 never stored
// - FCS is the complemented CCITT sum, high order bit first
`timescale 1ns/100ps
module hbf_framer
  import hbf_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  output logic      [7:0] cpu_rdata,
  input  wire logic       tx_clk_pin,
  output logic            tx_data,
  input  wire logic       rx_clk_pin,
  input  wire logic       rx_data_pin,
  output logic            tx_underrun
);
  // ==========================================================
  // pin synchronisers
  logic [2:0] txc_s;
  logic [2:0] rxc_s;
  logic [1:0] rxd_s;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txc_s <= 3'h0;
      rxc_s <= 3'h0;
      rxd_s <= 2'h0;
    end else begin
      txc_s <= {txc_s[1:0], tx_clk_pin};
      rxc_s <= {rxc_s[1:0], rx_clk_pin};
      rxd_s <= {rxd_s[0], rx_data_pin};
    end
  end
  // launch on the falling edge so the far end samples on the rising one
  wire tx_tick = txc_s[2] & ~txc_s[1];
  wire rx_tick = ~rxc_s[2] & rxc_s[1];
  wire rx_bit  = rxd_s[1];

  // ==========================================================
  // control registers
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] cnt_load;
  logic [7:0] cnt;
  logic       soft_clr;
  logic       txf_full;
  wire wr_ctrl1 = cpu_wr && cpu_addr == A_CTRL1;
  wire wr_fifo  = cpu_wr && cpu_addr == A_FIFO && !txf_full;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) soft_clr <= 1'b0;
    else soft_clr <= cpu_wr && cpu_addr == A_SRST && cpu_wdata[SR_BIT];
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1    <= 8'h00;
      ctrl2    <= 8'h00;
      cnt_load <= 8'h00;
      cnt      <= 8'h00;
    end else if (soft_clr) begin
      ctrl1    <= 8'h00;
      ctrl2    <= 8'h00;
      cnt_load <= 8'h00;
      cnt      <= 8'h00;
    end else begin
      if (wr_ctrl1) begin
        ctrl1 <= cpu_wdata;
      end else if (wr_fifo) begin
        ctrl1[C1_EOP] <= 1'b0;
        ctrl1[C1_FA]  <= 1'b0;
      end
      if (cpu_wr && cpu_addr == A_CTRL2) ctrl2 <= cpu_wdata;
      if (cpu_wr && cpu_addr == A_COUNT) begin
        cnt_load <= cpu_wdata;
        cnt      <= cpu_wdata;
      end else if (wr_fifo && cnt != 8'h00) begin
        cnt <= (cnt == 8'h01 && ctrl2[C2_CYC]) ? cnt_load : cnt - 8'h01;
      end
    end
  end

  // ==========================================================
  // transmit fifo
  hbf_tx_ent_t txf_mem [FIFO_DEPTH];
  logic [6:0]  txf_wp;
  logic [6:0]  txf_rp;
  logic [7:0]  txf_cnt;
  logic        txf_pop;
  wire         txf_empty = txf_cnt == 8'h00;
  wire hbf_tx_ent_t txf_head = txf_mem[txf_rp];
  assign txf_full = txf_cnt == FIFO_FULL;
  always_ff @(posedge core_clk) begin
    // tags are taken from control as it stands at the data write
    if (wr_fifo) txf_mem[txf_wp] <= '{fa: ctrl1[C1_FA],
                                      eop: ctrl1[C1_EOP] | (cnt == 8'h01),
                                      data: cpu_wdata};
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txf_wp  <= 7'h00;
      txf_rp  <= 7'h00;
      txf_cnt <= 8'h00;
    end else if (soft_clr) begin
      txf_wp  <= 7'h00;
      txf_rp  <= 7'h00;
      txf_cnt <= 8'h00;
    end else begin
      if (wr_fifo) txf_wp <= txf_wp + 7'h01;
      if (txf_pop) txf_rp <= txf_rp + 7'h01;
      txf_cnt <= txf_cnt + {7'h00, wr_fifo} - {7'h00, txf_pop};
    end
  end

  // ==========================================================
  // transmitter
  hbf_tx_st_t  tx_st;
  hbf_tx_st_t  next_st;
  logic [15:0] tx_sh;
  logic [15:0] next_sh;
  logic [4:0]  tx_left;
  logic [4:0]  next_len;
  logic        tx_stf;
  logic        next_stf;
  logic [3:0]  tx_ones;
  logic [15:0] tx_crc;
  logic        tx_last_eop;
  logic        urun;
  logic        tx_tail;
  wire tx_stuff_now = tx_stf && tx_ones == STUFF_RUN;
  wire tx_load      = tx_left == 5'h00 && !tx_stuff_now;
  wire tx_run       = ctrl1[C1_TRANSMIT_ENABLE_BIT] || tx_tail;
  wire tx_have      = !txf_empty && ctrl1[C1_TRANSMIT_ENABLE_BIT];

  always_comb begin
    next_st  = TX_IDLE;
    next_sh  = {8'h00, ONES};
    next_len = BYTE_BITS;
    next_stf = 1'b0;
    txf_pop  = 1'b0;
    urun     = 1'b0;
    unique case (tx_st)
      TX_DATA: begin
        if (tx_last_eop && !ctrl2[C2_NOFCS]) begin
          next_st  = TX_FCS;
          next_sh  = ~tx_crc;
          next_len = FCS_BITS;
          next_stf = 1'b1;
        end else if (tx_last_eop) begin
          next_st = TX_FLAG;
          next_sh = {8'h00, FLAG};
        end else if (!txf_empty) begin
          txf_pop  = tx_load;
          next_st  = txf_head.fa ? TX_ABORT : TX_DATA;
          next_sh  = {8'h00, txf_head.fa ? ABORT_PAT : txf_head.data};
          next_stf = !txf_head.fa;
        end else begin
          urun    = 1'b1;
          next_st = TX_ABORT;
          next_sh = {8'h00, ABORT_PAT};
        end
      end
      TX_FCS: begin
        next_st = TX_FLAG;
        next_sh = {8'h00, FLAG};
      end
      TX_FLAG: begin
        if (tx_have) begin
          txf_pop  = tx_load;
          next_st  = txf_head.fa ? TX_ABORT : TX_DATA;
          next_sh  = {8'h00, txf_head.fa ? ABORT_PAT : txf_head.data};
          next_stf = !txf_head.fa;
        end else if (ctrl1[C1_MARK]) begin
          next_st = TX_FLAG;
          next_sh = {8'h00, FLAG};
        end
      end
      TX_IDLE, TX_ABORT: begin
        if (tx_have || ctrl1[C1_MARK]) begin
          next_st = TX_FLAG;
          next_sh = {8'h00, FLAG};
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st       <= TX_IDLE;
      tx_sh       <= {8'h00, ONES};
      tx_left     <= BYTE_BITS;
      tx_stf      <= 1'b0;
      tx_ones     <= 4'h0;
      tx_crc      <= CRC_INIT;
      tx_last_eop <= 1'b0;
      tx_data     <= 1'b1;
      tx_tail     <= 1'b0;
    end else if (soft_clr) begin
      tx_st       <= TX_IDLE;
      tx_sh       <= {8'h00, ONES};
      tx_left     <= BYTE_BITS;
      tx_stf      <= 1'b0;
      tx_ones     <= 4'h0;
      tx_crc      <= CRC_INIT;
      tx_last_eop <= 1'b0;
      tx_data     <= 1'b1;
      tx_tail     <= 1'b0;
    end else if (tx_load) begin
      tx_st   <= next_st;
      // fcs, closing flag or abort after a data byte still belong to the packet
      tx_tail <= next_st == TX_DATA || next_st == TX_FCS ||
                 tx_st == TX_DATA || tx_st == TX_FCS;
      tx_sh   <= next_sh;
      tx_left <= next_len;
      tx_stf  <= next_stf;
      if (txf_pop) tx_last_eop <= txf_head.eop;
      if (next_st == TX_DATA && tx_st != TX_DATA) tx_crc <= CRC_INIT;
    end else if (tx_tick && tx_run) begin
      if (tx_stuff_now) begin
        tx_data <= 1'b0;
        tx_ones <= 4'h0;
      end else begin
        tx_data <= tx_sh[0];
        tx_sh   <= tx_sh >> 1;
        tx_left <= tx_left - 5'h01;
        tx_ones <= (tx_sh[0] && tx_stf) ? tx_ones + 4'h1 : 4'h0;
        if (tx_st == TX_DATA) tx_crc <= crc_step(tx_crc, tx_sh[0]);
      end
    end
  end

  wire clr_undr = cpu_wr && cpu_addr == A_STAT && cpu_wdata[ST_UNDR];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) tx_underrun <= 1'b0;
    else if (soft_clr) tx_underrun <= 1'b0;
    else if (urun && tx_load) tx_underrun <= 1'b1;
    else if (clr_undr) tx_underrun <= 1'b0;
  end

  // ==========================================================
  // receiver; bytes lag the line by 23 bits so flag and FCS never land
  logic [3:0]  rx_ones;
  logic        rx_in;
  logic [5:0]  rx_len;
  logic [2:0]  rx_ph;
  logic [30:0] rx_hist;
  logic [15:0] rx_crc;
  logic [7:0]  rx_pend;
  logic        rx_pv;
  logic        rx_wr;
  hbf_rx_ent_t rx_wd;
  logic        go_ahead;
  wire       rx_flag  = rx_tick && !rx_bit && rx_ones == FLAG_RUN;
  wire       rx_del   = rx_tick && !rx_bit && rx_ones == STUFF_RUN && rx_in;
  wire       rx_abort = rx_tick && rx_bit && rx_ones == ABORT_RUN - 4'h1 && rx_in;
  wire       rx_enter = rx_tick && rx_in && !rx_flag && !rx_del && !rx_abort;
  wire [5:0] rx_dlen  = rx_len - FLAG_TAIL;
  wire [2:0] next_ph  = rx_ph + 3'h1;
  wire       rx_bad   = rx_dlen < LEN_GOOD || rx_crc != CRC_GOOD || rx_ph != EMIT_PH;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ones <= 4'h0;
      rx_in   <= 1'b0;
      rx_len  <= 6'h00;
      rx_ph   <= 3'h0;
      rx_hist <= 31'h0;
      rx_crc  <= CRC_INIT;
      rx_pend <= 8'h00;
      rx_pv   <= 1'b0;
      rx_wr   <= 1'b0;
      rx_wd   <= '0;
    end else if (soft_clr) begin
      rx_ones <= 4'h0;
      rx_in   <= 1'b0;
      rx_pv   <= 1'b0;
      rx_wr   <= 1'b0;
    end else begin
      rx_wr <= 1'b0;
      if (rx_tick) begin
        if (!rx_bit) rx_ones <= 4'h0;
        else if (rx_ones != IDLE_RUN) rx_ones <= rx_ones + 4'h1;
      end
      if (rx_flag) begin
        if (rx_in && rx_pv && rx_dlen >= LEN_MIN) begin
          rx_wr <= 1'b1;
          rx_wd <= '{hi: 1'b1, lo: rx_bad, data: rx_pend};
        end
        rx_in  <= ctrl1[C1_RECEIVE_ENABLE_BIT];
        rx_len <= 6'h00;
        rx_ph  <= 3'h0;
        rx_crc <= CRC_INIT;
        rx_pv  <= 1'b0;
      end
      if (rx_abort) begin
        // the pending byte trails the line by 23 bits, so it holds none of the abort run
        if (rx_pv && rx_dlen >= LEN_ABORT) begin
          rx_wr <= 1'b1;
          rx_wd <= '{hi: RX_LBAD[1], lo: RX_LBAD[0], data: rx_pend};
        end
        rx_in <= 1'b0;
        rx_pv <= 1'b0;
      end
      if (rx_enter) begin
        rx_hist <= {rx_bit, rx_hist[30:1]};
        rx_ph   <= next_ph;
        if (rx_len != 6'h3f) rx_len <= rx_len + 6'h01;
        if (rx_len >= FLAG_TAIL) rx_crc <= crc_step(rx_crc, rx_hist[24]);
        // the length saturates, so a long frame keeps emitting on the phase alone
        if ((rx_len == 6'h3f || rx_len + 6'h01 >= EMIT_LEN) && next_ph == EMIT_PH) begin
          rx_pend <= rx_hist[8:1];
          rx_pv   <= 1'b1;
          if (rx_pv) begin
            rx_wr <= 1'b1;
            rx_wd <= '{hi: RX_PLAIN[1], lo: RX_PLAIN[0], data: rx_pend};
          end
        end
      end
    end
  end

  wire clr_goah = cpu_wr && cpu_addr == A_STAT && cpu_wdata[ST_GOAH];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) go_ahead <= 1'b0;
    else if (soft_clr) go_ahead <= 1'b0;
    else if (rx_tick && !rx_bit && rx_ones == ABORT_RUN) go_ahead <= 1'b1;
    else if (clr_goah) go_ahead <= 1'b0;
  end

  // ==========================================================
  // receive fifo; a full fifo drops the incoming byte
  hbf_rx_ent_t rxf_mem [FIFO_DEPTH];
  logic [6:0]  rxf_wp;
  logic [6:0]  rxf_rp;
  logic [7:0]  rxf_cnt;
  wire         rxf_empty = rxf_cnt == 8'h00;
  wire         rxf_push  = rx_wr && rxf_cnt != FIFO_FULL;
  wire         rxf_pop   = cpu_rd && cpu_addr == A_FIFO && !rxf_empty;
  wire hbf_rx_ent_t rxf_head = rxf_mem[rxf_rp];
  always_ff @(posedge core_clk) begin
    if (rxf_push) rxf_mem[rxf_wp] <= rx_wd;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxf_wp  <= 7'h00;
      rxf_rp  <= 7'h00;
      rxf_cnt <= 8'h00;
    end else if (soft_clr) begin
      rxf_wp  <= 7'h00;
      rxf_rp  <= 7'h00;
      rxf_cnt <= 8'h00;
    end else begin
      if (rxf_push) rxf_wp <= rxf_wp + 7'h01;
      if (rxf_pop) rxf_rp <= rxf_rp + 7'h01;
      rxf_cnt <= rxf_cnt + {7'h00, rxf_push} - {7'h00, rxf_pop};
    end
  end

  // ==========================================================
  // read port; status shows the byte about to be read
  wire [7:0] stat = {rxf_head.hi & !rxf_empty, rxf_head.lo & !rxf_empty, 1'b0,
                     txf_full, rx_ones == IDLE_RUN, go_ahead, tx_underrun, rxf_empty};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cpu_rdata <= 8'h00;
    else if (cpu_rd) begin
      unique case (cpu_addr)
        A_CTRL1: cpu_rdata <= ctrl1;
        A_STAT:  cpu_rdata <= stat;
        A_CTRL2: cpu_rdata <= ctrl2;
        A_COUNT: cpu_rdata <= cnt;
        A_FIFO:  cpu_rdata <= rxf_head.data;
        default: cpu_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_tag_write;
    wr_fifo && cnt == 8'h01;
  endsequence
  sequence s_short_flag;
    rx_flag && rx_in && rx_dlen < LEN_MIN;
  endsequence
  a_tx_zero_insert: assert property (tx_tick && tx_run && !tx_load && tx_stuff_now |=> !tx_data) else $error("no stuffed zero");
  a_rx_zero_drop: assert property (rx_del |=> rx_len == $past(rx_len)) else $error("stuffed zero kept");
  a_short_drop: assert property (s_short_flag |=> !rx_wr) else $error("short frame stored");
  a_bad_tag: assert property (rx_flag && rx_in && rx_pv && rx_dlen >= LEN_MIN && rx_bad |=> rx_wr && rx_wd.hi && rx_wd.lo) else $error("bad frame not tagged");
  a_abort_tag: assert property (rx_abort && rx_pv && rx_dlen >= LEN_ABORT |=> rx_wr && rx_wd.lo ##1 !rx_in) else $error("abort not tagged");
  a_tag_clear: assert property (wr_fifo && !soft_clr |=> !ctrl1[C1_EOP] && !ctrl1[C1_FA]) else $error("tags kept");
  a_count_eop: assert property (s_tag_write |=> txf_mem[$past(txf_wp)].eop) else $error("count tag missing");
  a_count_down: assert property (wr_fifo && cnt > 8'h01 && !soft_clr |=> cnt == $past(cnt) - 8'h01) else $error("count not stepped");
  a_soft_clear: assert property (soft_clr |=> ctrl1 == 8'h00 && tx_st == TX_IDLE && !rx_in) else $error("soft reset left state");
  a_underrun: assert property (urun && tx_load && !soft_clr |=> tx_underrun && tx_st == TX_ABORT) else $error("underrun not flagged");
  a_fcs_follow: assert property (tx_load && tx_st == TX_DATA && tx_last_eop && !ctrl2[C2_NOFCS] && !soft_clr |=> tx_st == TX_FCS && tx_left == FCS_BITS) else $error("no fcs");
endmodule  // hbf_framer

// >>> verilog/hbf_pkg.sv
/*
  Shared constants and types of the bit-oriented packet framer: register
  offsets, control and status bit positions, link patterns, run lengths,
  frame length limits, FIFO shape, entry layouts and the FCS step.
  Assumes a single core clock domain; nothing here is clocked.
*/
package hbf_pkg;
  // ==========================================================
  // register map and bit positions
  localparam logic [7:0] A_CTRL1 = 8'h13;
  localparam logic [7:0] A_STAT  = 8'h14;
  localparam logic [7:0] A_CTRL2 = 8'h15;
  localparam logic [7:0] A_COUNT = 8'h16;
  localparam logic [7:0] A_FIFO  = 8'h17;
  localparam logic [7:0] A_SRST  = 8'h1b;
  localparam int C1_RECEIVE_ENABLE_BIT = 6;
  localparam int C1_TRANSMIT_ENABLE_BIT = 5;
  localparam int C1_EOP  = 4;
  localparam int C1_FA   = 3;
  localparam int C1_MARK = 2;
  localparam int C2_CYC  = 0;
  localparam int C2_NOFCS = 1;
  localparam int SR_BIT  = 0;
  localparam int ST_UNDR = 1;
  localparam int ST_GOAH = 2;
  // ==========================================================
  // link patterns, run lengths and frame limits
  localparam logic [7:0]  FLAG      = 8'h7e;
  localparam logic [7:0]  ABORT_PAT = 8'hfe;  // sent lsb first: 0 then seven 1s
  localparam logic [7:0]  ONES      = 8'hff;
  localparam logic [4:0]  BYTE_BITS = 5'd8;
  localparam logic [4:0]  FCS_BITS  = 5'd16;
  localparam logic [15:0] CRC_INIT  = 16'hffff;
  localparam logic [15:0] CRC_POLY  = 16'h8408;
  localparam logic [15:0] CRC_GOOD  = 16'hf0b8;
  localparam logic [3:0]  STUFF_RUN = 4'd5;
  localparam logic [3:0]  FLAG_RUN  = 4'd6;
  localparam logic [3:0]  ABORT_RUN = 4'd7;
  localparam logic [3:0]  IDLE_RUN  = 4'd15;
  localparam logic [5:0]  FLAG_TAIL = 6'd7;
  localparam logic [5:0]  EMIT_LEN  = 6'd31;
  localparam logic [2:0]  EMIT_PH   = 3'd7;
  localparam logic [5:0]  LEN_MIN   = 6'd25;
  localparam logic [5:0]  LEN_ABORT = 6'd26;
  localparam logic [5:0]  LEN_GOOD  = 6'd32;
  localparam logic [1:0]  RX_PLAIN  = 2'b00;
  localparam logic [1:0]  RX_LGOOD  = 2'b10;
  localparam logic [1:0]  RX_LBAD   = 2'b11;
  // ==========================================================
  // fifo shape and types
  localparam int         FIFO_DEPTH = 128;
  localparam logic [7:0] FIFO_FULL  = 8'd128;
  typedef struct packed {logic fa; logic eop; logic [7:0] data;} hbf_tx_ent_t;
  typedef struct packed {logic hi; logic lo; logic [7:0] data;} hbf_rx_ent_t;
  typedef enum logic [4:0] {TX_IDLE = 5'b00001, TX_FLAG = 5'b00010, TX_DATA = 5'b00100,
                            TX_FCS = 5'b01000, TX_ABORT = 5'b10000} hbf_tx_st_t;

  // one fcs bit, reflected register, shared by both directions
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction
endpackage
